// *** rtl/cstc_pkg.sv ***
// charge safety timer configuration: register map, field layout, reset values,
// charge phases and timer limits.
// assumes a single 250 MHz clock shared by every user of the package.
package cstc_pkg;

   // register offsets on the serial control register port
   localparam logic [7:0]  OFS_FIXED_B    = 8'h0B;
   localparam logic [7:0]  OFS_PREPHASE   = 8'h0D;
   localparam logic [7:0]  OFS_SAFETY     = 8'h0E;

   // reset values
   localparam logic [15:0] FIXED_B_VAL    = 16'h00DC;
   localparam logic [6:0]  PREPHASE_RSV   = 7'h4B;
   localparam logic        PREPHASE_SEL_RST = 1'b0;
   localparam logic [7:0]  SAFETY_RST     = 8'h3D;

   // field positions
   localparam int          POS_PRE_SEL    = 7;
   localparam int          POS_FIN_HI     = 7;
   localparam int          POS_FIN_LO     = 6;
   localparam int          POS_TRK_EN     = 5;
   localparam int          POS_PRE_EN     = 4;
   localparam int          POS_FAST_EN    = 3;
   localparam int          POS_FDUR_HI    = 2;
   localparam int          POS_FDUR_LO    = 1;
   localparam int          POS_HALFRATE   = 0;

   // time base
   localparam int          CLK_PERIOD_NS  = 4;
   localparam int          SEC_NS         = 1000000000;
   localparam int          TICK_CYCLES    = SEC_NS / CLK_PERIOD_NS;
   localparam int          SEC_PER_HR     = 3600;
   localparam int          SEC_PER_MIN    = 60;

   // limits in their printed units
   localparam int          TRICKLE_HR     = 1;
   localparam int          PRE_LONG_HR    = 2;
   localparam int          PRE_SHORT_MIN  = 30;
   localparam int          FAST_HR_0      = 5;
   localparam int          FAST_HR_1      = 8;
   localparam int          FAST_HR_2      = 12;
   localparam int          FAST_HR_3      = 24;
   localparam int          FIN_MIN_1      = 15;
   localparam int          FIN_MIN_2      = 30;
   localparam int          FIN_MIN_3      = 45;

   localparam int          SEC_W          = 17;
   localparam logic [SEC_W-1:0] TRICKLE_S   = SEC_W'(TRICKLE_HR * SEC_PER_HR);
   localparam logic [SEC_W-1:0] PRE_LONG_S  = SEC_W'(PRE_LONG_HR * SEC_PER_HR);
   localparam logic [SEC_W-1:0] PRE_SHORT_S = SEC_W'(PRE_SHORT_MIN * SEC_PER_MIN);
   localparam logic [SEC_W-1:0] FAST_S_0    = SEC_W'(FAST_HR_0 * SEC_PER_HR);
   localparam logic [SEC_W-1:0] FAST_S_1    = SEC_W'(FAST_HR_1 * SEC_PER_HR);
   localparam logic [SEC_W-1:0] FAST_S_2    = SEC_W'(FAST_HR_2 * SEC_PER_HR);
   localparam logic [SEC_W-1:0] FAST_S_3    = SEC_W'(FAST_HR_3 * SEC_PER_HR);
   localparam logic [SEC_W-1:0] FIN_S_1     = SEC_W'(FIN_MIN_1 * SEC_PER_MIN);
   localparam logic [SEC_W-1:0] FIN_S_2     = SEC_W'(FIN_MIN_2 * SEC_PER_MIN);
   localparam logic [SEC_W-1:0] FIN_S_3     = SEC_W'(FIN_MIN_3 * SEC_PER_MIN);

   typedef enum logic [2:0]
   {
      PH_IDLE    = 3'b000,
      PH_TRICKLE = 3'b001,
      PH_PRE     = 3'b010,
      PH_FAST    = 3'b011,
      PH_TOPOFF  = 3'b100
   } cstc_phase_t;

endpackage

// *** rtl/cstc_guard_timer.sv ***
// one elapsed-time counter in whole seconds with an optional half-speed mode.
// assumes the caller clears it on every phase change; only one phase runs at a time.
`timescale 1ns/10ps
module cstc_guard_timer
   import cstc_pkg::*;
#(
   parameter int TICK = TICK_CYCLES
)
(
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             ce,
   input  wire logic             clear,
   input  wire logic             run,
   input  wire logic             slow,
   input  wire logic [SEC_W-1:0] limit_s,
   output      logic             expire
);

   typedef struct packed
   {
      logic [31:0]      pre;
      logic             half;
      logic [SEC_W-1:0] sec;
      logic             done;
      logic             expire;
   } cstc_gt_st_t;

   cstc_gt_st_t q;
   cstc_gt_st_t d;

   always_comb
   begin
      d        = q;
      d.expire = 1'b0;
      if (clear)
      begin
         d.pre  = 32'h0000_0000;
         d.half = 1'b0;
         d.sec  = '0;
         d.done = 1'b0;
      end
      else if (run && !q.done)
      begin
         // half speed: prescaler only steps on every other cycle
         d.half = ~q.half;
         if (!slow || q.half)
         begin
            if (q.pre == 32'(TICK - 1))
            begin
               d.pre = 32'h0000_0000;
               d.sec = q.sec + 1'b1;
               if (q.sec + 1'b1 >= limit_s)
               begin
                  d.done   = 1'b1;
                  d.expire = 1'b1;
               end
            end
            else
            begin
               d.pre = q.pre + 32'h0000_0001;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         q <= '0;
      else if (ce)
         q <= d;
   end

   assign expire = q.expire;

endmodule

// *** rtl/cstc_safety_timer.sv ***
// safety timer configuration registers and the phase guard timer they steer.
// assumes the charge state machine drives phase on this clock, and that the
// serial control interface delivers decoded single-cycle register strobes.
`timescale 1ns/10ps
module cstc_safety_timer
   import cstc_pkg::*;
#(
   parameter int TICK = TICK_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output      logic [15:0] reg_rdata,
   input  wire logic        reg_rst,
   input  wire logic        wdog_expire,
   input  wire cstc_phase_t phase,
   input  wire logic        input_power_limiting,
   input  wire logic        thermal_reg,
   output      logic        phase_end,
   output      logic        timer_fault,
   output      logic [7:0]  safety_cfg,
   output      logic        prephase_timeout_select
);

   typedef struct packed
   {
      logic        pre_sel;
      logic [7:0]  tmr_cfg;
      logic        dpm_s1;
      logic        dpm_s2;
      logic        thr_s1;
      logic        thr_s2;
      logic [2:0]  ph_prev;
      logic        fault;
      logic [15:0] rd_data;
   } cstc_st_t;

   localparam cstc_st_t ST_RST = '{pre_sel: PREPHASE_SEL_RST, tmr_cfg: SAFETY_RST,
                                   dpm_s1: 1'b0, dpm_s2: 1'b0, thr_s1: 1'b0, thr_s2: 1'b0,
                                   ph_prev: PH_IDLE, fault: 1'b0, rd_data: 16'h0000};

   cstc_st_t         q;
   cstc_st_t         d;
   logic             run;
   logic             slow;
   logic             clear;
   logic             expire;
   logic [SEC_W-1:0] limit_s;
   logic [1:0]       finish_extend_duration;
   logic [1:0]       fast_guard_duration;
   logic             trickle_guard_enable;
   logic             prephase_guard_enable;
   logic             fast_guard_enable;
   logic             slow_guard_halfrate;

   assign finish_extend_duration = q.tmr_cfg[POS_FIN_HI:POS_FIN_LO];
   assign fast_guard_duration    = q.tmr_cfg[POS_FDUR_HI:POS_FDUR_LO];
   assign trickle_guard_enable   = q.tmr_cfg[POS_TRK_EN];
   assign prephase_guard_enable  = q.tmr_cfg[POS_PRE_EN];
   assign fast_guard_enable      = q.tmr_cfg[POS_FAST_EN];
   assign slow_guard_halfrate    = q.tmr_cfg[POS_HALFRATE];

   // limit and gating for whichever phase is running
   always_comb
   begin
      run     = 1'b0;
      limit_s = TRICKLE_S;
      case (phase)
         PH_TRICKLE:
         begin
            run     = trickle_guard_enable;
            limit_s = TRICKLE_S;
         end
         PH_PRE:
         begin
            run     = prephase_guard_enable;
            limit_s = q.pre_sel ? PRE_SHORT_S : PRE_LONG_S;
         end
         PH_FAST:
         begin
            run = fast_guard_enable;
            case (fast_guard_duration)
               2'h0:    limit_s = FAST_S_0;
               2'h1:    limit_s = FAST_S_1;
               2'h2:    limit_s = FAST_S_2;
               default: limit_s = FAST_S_3;
            endcase
         end
         PH_TOPOFF:
         begin
            run = (finish_extend_duration != 2'h0);
            case (finish_extend_duration)
               2'h1:    limit_s = FIN_S_1;
               2'h2:    limit_s = FIN_S_2;
               default: limit_s = FIN_S_3;
            endcase
         end
         default:
         begin
            run     = 1'b0;
            limit_s = TRICKLE_S;
         end
      endcase
   end

   // top-off is not among the slowed timers
   assign slow  = slow_guard_halfrate && (q.dpm_s2 || q.thr_s2) && (phase != PH_TOPOFF);
   assign clear = (phase != q.ph_prev) || reg_rst;

   cstc_guard_timer #(
      .TICK    (TICK)
   ) u_timer (
      .clk     (clk),
      .arst_n  (arst_n),
      .ce      (ce),
      .clear   (clear),
      .run     (run),
      .slow    (slow),
      .limit_s (limit_s),
      .expire  (expire)
   );

   always_comb
   begin
      d         = q;
      d.dpm_s1  = input_power_limiting;
      d.dpm_s2  = q.dpm_s1;
      d.thr_s1  = thermal_reg;
      d.thr_s2  = q.thr_s1;
      d.ph_prev = phase;
      if (reg_rst || wdog_expire)
      begin
         d.pre_sel = PREPHASE_SEL_RST;
         d.tmr_cfg = SAFETY_RST;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            OFS_PREPHASE: d.pre_sel = reg_wdata[POS_PRE_SEL];
            OFS_SAFETY:   d.tmr_cfg = reg_wdata;
            default:      d.tmr_cfg = q.tmr_cfg;
         endcase
      end
      // clear first so an expiry in the same cycle wins
      if (phase != q.ph_prev || reg_rst)
         d.fault = 1'b0;
      if (expire)
         d.fault = 1'b1;
      if (reg_rd)
      begin
         case (reg_addr)
            OFS_FIXED_B:  d.rd_data = FIXED_B_VAL;
            OFS_PREPHASE: d.rd_data = {8'h00, q.pre_sel, PREPHASE_RSV};
            OFS_SAFETY:   d.rd_data = {8'h00, q.tmr_cfg};
            default:      d.rd_data = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         q <= ST_RST;
      else if (ce)
         q <= d;
   end

   assign reg_rdata               = q.rd_data;
   assign phase_end               = expire;
   assign timer_fault             = q.fault;
   assign safety_cfg              = q.tmr_cfg;
   assign prephase_timeout_select = q.pre_sel;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   property p_fixed_read;
      ce && reg_rd && reg_addr == OFS_FIXED_B |=> reg_rdata == FIXED_B_VAL;
   endproperty
   a_fixed_read: assert property (p_fixed_read) else $error("fixed register read wrong");

   property p_pre_read;
      ce && reg_rd && reg_addr == OFS_PREPHASE |=> reg_rdata[6:0] == PREPHASE_RSV && reg_rdata[7] == $past(q.pre_sel);
   endproperty
   a_pre_read: assert property (p_pre_read) else $error("pre-charge register read wrong");

   property p_defaults;
      ce && (reg_rst || wdog_expire) |=> safety_cfg == SAFETY_RST && !prephase_timeout_select;
   endproperty
   a_defaults: assert property (p_defaults) else $error("defaults not restored");

   property p_cfg_stable;
      ce && !reg_rst && !wdog_expire && !(reg_wr && reg_addr == OFS_SAFETY) |=> $stable(safety_cfg);
   endproperty
   a_cfg_stable: assert property (p_cfg_stable) else $error("timer control changed unprompted");

   property p_pre_limit;
      phase == PH_PRE |-> limit_s == (prephase_timeout_select ? PRE_SHORT_S : PRE_LONG_S) && run == prephase_guard_enable;
   endproperty
   a_pre_limit: assert property (p_pre_limit) else $error("pre-charge limit wrong");

   property p_topoff_off;
      phase == PH_TOPOFF && finish_extend_duration == 2'h0 |-> !run;
   endproperty
   a_topoff_off: assert property (p_topoff_off) else $error("top-off timer ran while disabled");

   property p_trickle;
      phase == PH_TRICKLE |-> run == trickle_guard_enable && limit_s == TRICKLE_S;
   endproperty
   a_trickle: assert property (p_trickle) else $error("trickle timer gating wrong");

   property p_fast;
      phase == PH_FAST && !fast_guard_enable |-> !run;
   endproperty
   a_fast: assert property (p_fast) else $error("fast timer ran while disabled");

   property p_fast_dur;
      phase == PH_FAST && fast_guard_duration == 2'h2 |-> limit_s == FAST_S_2;
   endproperty
   a_fast_dur: assert property (p_fast_dur) else $error("fast duration decode wrong");

   // either pin, seen two cycles back through the synchroniser, slows the trickle, pre-charge or fast timer
   property p_slow;
      ce && $past(ce) && $past(ce, 2) && $past(arst_n, 2) && slow_guard_halfrate
         && ($past(input_power_limiting, 2) || $past(thermal_reg, 2))
         && (phase == PH_TRICKLE || phase == PH_PRE || phase == PH_FAST) |-> slow;
   endproperty
   a_slow: assert property (p_slow) else $error("half rate not applied");

   property p_fault;
      ce && expire |=> timer_fault;
   endproperty
   a_fault: assert property (p_fault) else $error("expiry did not raise status");

   c_expire:   cover property (ce && expire);
   c_reg_rst:  cover property (ce && reg_rst);
   c_slow_run: cover property (run && slow);
   c_wr_cfg:   cover property (ce && reg_wr && reg_addr == OFS_SAFETY);

endmodule

// *** verif/cstc_safety_timer_tb.sv ***
// self-checking bench for the safety timer configuration block.
// assumes the design carries its own assertions; bench drives all ports itself.
`timescale 1ns/10ps
module cstc_safety_timer_tb;
   import cstc_pkg::*;

   localparam int TK = 2;

   typedef struct packed
   {
      logic [7:0]  a;
      logic [7:0]  d;
      logic [15:0] r;
   } cstc_row_t;

   logic        clk;
   logic        arst_n;
   logic        ce;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [15:0] reg_rdata;
   logic        reg_rst;
   logic        wdog_expire;
   cstc_phase_t phase;
   logic        input_power_limiting;
   logic        thermal_reg;
   logic        phase_end;
   logic        timer_fault;
   logic [7:0]  safety_cfg;
   logic        prephase_timeout_select;
   int          n_fail;
   int          num_checks;
   cstc_row_t   rows [8];

   cstc_safety_timer #(.TICK(TK)) i_cstc_safety_timer
   (
      .clk                     (clk),
      .arst_n                  (arst_n),
      .ce                      (ce),
      .reg_wr                  (reg_wr),
      .reg_rd                  (reg_rd),
      .reg_addr                (reg_addr),
      .reg_wdata               (reg_wdata),
      .reg_rdata               (reg_rdata),
      .reg_rst                 (reg_rst),
      .wdog_expire             (wdog_expire),
      .phase                   (phase),
      .input_power_limiting    (input_power_limiting),
      .thermal_reg             (thermal_reg),
      .phase_end               (phase_end),
      .timer_fault             (timer_fault),
      .safety_cfg              (safety_cfg),
      .prephase_timeout_select (prephase_timeout_select)
   );

   always #2 clk = ~clk;

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // timer figures are reckoned in cycles; a few cycles of pipeline slack allowed
   task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
      num_checks++;
      if (got < lo || got > hi)
      begin
         n_fail++;
         $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] q);
      reg_rd   = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      q      = reg_rdata;
      @(negedge clk);
   endtask

   task automatic pulse_rst(input logic wd);
      if (wd)
         wdog_expire = 1'b1;
      else
         reg_rst = 1'b1;
      @(negedge clk);
      wdog_expire = 1'b0;
      reg_rst     = 1'b0;
   endtask

   // restart from idle, then count cycles to the expiry pulse
   task automatic run_ph(input cstc_phase_t ph, input int exp, input string nm);
      int n;
      phase = PH_IDLE;
      repeat (4) @(negedge clk);
      phase = ph;
      n     = 0;
      while (phase_end !== 1'b1 && n < exp + 50)
      begin
         @(negedge clk);
         n++;
      end
      chk_rng(nm, exp - 2, exp + 8, n);
      @(negedge clk);
      chk("timer_fault", 16'h0001, {15'h0000, timer_fault});
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (90000) @(posedge clk);
      n_fail++;
      $display("[ERR] watchdog expired before tests ended");
      results();
   end

   initial
   begin : main
      logic [15:0] q;
      int          k;
      clk = 1'b0; arst_n = 1'b0; ce = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
      reg_addr = 8'h00; reg_wdata = 8'h00; reg_rst = 1'b0; wdog_expire = 1'b0;
      phase = PH_IDLE; input_power_limiting = 1'b0; thermal_reg = 1'b0;
      n_fail = 0; num_checks = 0;
      rows[0] = {OFS_SAFETY, 8'h00, 16'h0000};
      rows[1] = {OFS_SAFETY, 8'hFF, 16'h00FF};
      rows[2] = {OFS_SAFETY, 8'hC2, 16'h00C2};
      rows[3] = {OFS_PREPHASE, 8'hFF, 16'h00CB};
      rows[4] = {OFS_PREPHASE, 8'h00, 16'h004B};
      rows[5] = {OFS_FIXED_B, 8'h00, 16'h00DC};
      rows[6] = {8'h20, 8'h55, 16'h0000};
      rows[7] = {OFS_SAFETY, 8'h3D, 16'h003D};
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      chk("safety_cfg rst", 16'h003D, {8'h00, safety_cfg});
      rd(OFS_FIXED_B, q);
      chk("rd 0B rst", 16'h00DC, q);
      rd(OFS_PREPHASE, q);
      chk("rd 0D rst", 16'h004B, q);
      rd(OFS_SAFETY, q);
      chk("rd 0E rst", 16'h003D, q);
      // clock enable low must freeze the register file
      ce = 1'b0;
      wr(OFS_SAFETY, 8'h00);
      chk("cfg ce low", 16'h003D, {8'h00, safety_cfg});
      ce = 1'b1;
      @(negedge clk);
      for (k = 0; k < 8; k++)
      begin
         wr(rows[k].a, rows[k].d);
         rd(rows[k].a, q);
         chk($sformatf("row %0d rdata", k), rows[k].r, q);
      end
      // both reset sources must restore every writable field
      for (k = 0; k < 2; k++)
      begin
         wr(OFS_SAFETY, 8'h00);
         wr(OFS_PREPHASE, 8'h80);
         chk("sel set", 16'h0001, {15'h0000, prephase_timeout_select});
         pulse_rst(k[0]);
         chk("cfg after reset", 16'h003D, {8'h00, safety_cfg});
         chk("sel after reset", 16'h0000, {15'h0000, prephase_timeout_select});
      end
      // top-off is not slowed even under thermal regulation
      thermal_reg = 1'b1;
      for (k = 1; k < 4; k++)
      begin
         wr(OFS_SAFETY, {k[1:0], 6'h3D});
         run_ph(PH_TOPOFF, k * 15 * 60 * TK, "topoff cycles");
      end
      wr(OFS_SAFETY, 8'h3D);
      phase = PH_IDLE;
      repeat (2) @(negedge clk);
      phase = PH_TOPOFF;
      k     = 0;
      repeat (2000)
      begin
         @(negedge clk);
         k = k + (phase_end === 1'b1 ? 1 : 0);
      end
      chk("topoff off pulses", 16'h0000, k[15:0]);
      thermal_reg          = 1'b0;
      input_power_limiting = 1'b1;
      // half-rate bit cleared: limiting must not slow the count
      wr(OFS_SAFETY, 8'h3C);
      wr(OFS_PREPHASE, 8'h80);
      run_ph(PH_PRE, 1800 * TK, "pre short cycles");
      repeat (3) @(negedge clk);
      chk("fault sticky", 16'h0001, {15'h0000, timer_fault});
      pulse_rst(1'b0);
      @(negedge clk);
      chk("fault cleared", 16'h0000, {15'h0000, timer_fault});
      run_ph(PH_TRICKLE, 2 * 3600 * TK, "trickle half cycles");
      input_power_limiting = 1'b0;
      // thermal regulation alone also halves the pre-charge count
      thermal_reg = 1'b1;
      wr(OFS_PREPHASE, 8'h80);
      run_ph(PH_PRE, 2 * 1800 * TK, "pre thermal half cycles");
      thermal_reg = 1'b0;
      wr(OFS_SAFETY, 8'h39);
      run_ph(PH_FAST, 5 * 3600 * TK, "fast 5h cycles");
      phase = PH_IDLE;
      repeat (2) @(negedge clk);
      results();
   end

endmodule
